// ==== hw/spi_reg_pkg.sv ====
// constants and helpers shared by both ends of the serial register port
`default_nettype none
package spi_reg_pkg;
    localparam logic [4:0] CW_BITS = 5'h10;
    localparam logic [4:0] BYTE_BITS = 5'h08;
    localparam logic [2:0] BYTE_LAST = 3'h7;
    localparam logic [13:0] ORDER_ADDR = 14'h3fff;
    localparam int ORDER_B0 = 3;
    localparam int ORDER_B1 = 4;
    localparam logic [7:0] ORDER_RST = 8'h00;
    localparam logic [3:0] HALF_CYC = 4'h8;
    localparam logic [31:0] OFS_CFG = 32'h0000_0000;
    localparam logic [31:0] OFS_CMD = 32'h0000_0004;
    localparam logic [31:0] OFS_TX = 32'h0000_0008;
    localparam logic [31:0] OFS_RX = 32'h0000_000c;
    localparam logic [31:0] OFS_STAT = 32'h0000_0010;
    localparam logic [2:0] CFG_RST = 3'h0;
    localparam int CFG_CPOL = 0;
    localparam int CFG_CPHA = 1;
    localparam int CFG_LSB = 2;
    localparam int CMD_RW = 14;
    localparam int CMD_BURST = 15;
    localparam int CMD_CNT = 16;
    localparam int CMD_ABORT = 31;
    localparam int ST_BUSY = 0;
    localparam int ST_TXE = 1;
    localparam int ST_RXV = 2;

    function automatic logic [13:0] rev14(input logic [13:0] a);
        logic [13:0] r;
        r = 14'h0000;
        for (int i = 0; i < 14; i++) begin
            r[i] = a[13-i];
        end
        return r;
    endfunction : rev14

    function automatic logic [7:0] rev8(input logic [7:0] a);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = a[7-i];
        end
        return r;
    endfunction : rev8
endpackage : spi_reg_pkg
`default_nettype wire

// ==== hw/spi_link_if.sv ====
// serial link between the register port and its bus master
`default_nettype none
interface spi_link_if;
    logic csN;
    logic sclk;
    logic sdi;
    logic sdiOe;
    logic sdo;
    logic sdoOe;

    modport device (
        input csN,
        input sclk,
        input sdi,
        output sdo,
        output sdoOe
    );

    modport host (
        output csN,
        output sclk,
        output sdi,
        output sdiOe,
        input sdo
    );
endinterface : spi_link_if
`default_nettype wire

// ==== hw/spi_slave_end.sv ====
// device end: serial slave reaching a byte-wide register space
`default_nettype none
module spi_slave_end (
    input wire logic sys_clk,
    input wire logic rst_n,
    spi_link_if.device link,
    input wire logic cpolStrap,
    input wire logic cphaStrap,
    output logic regWrEn,
    output logic [13:0] regWrAddr,
    output logic [7:0] regWrData,
    output logic [13:0] regRdAddr,
    input wire logic [7:0] regRdData,
    output logic [7:0] orderReg,
    output logic selActive
);
    logic [1:0] csS;
    logic [2:0] sckS;
    logic [1:0] sdiS;
    logic [1:0] polS;
    logic [1:0] phaS;
    logic selected;
    logic rise;
    logic fall;
    logic lead;
    logic trail;
    logic capE;
    logic shfE;
    logic lsb;
    logic [4:0] bitCnt;
    logic [14:0] cwSh;
    logic [15:0] cwWord;
    logic cwDone;
    logic lastCw;
    logic rdR;
    logic burstR;
    logic doneR;
    logic [13:0] addrR;
    logic [7:0] orderR;
    logic [2:0] rxCnt;
    logic [7:0] rxSh;
    logic [7:0] rxByte;
    logic wrBit;
    logic commit;
    logic [2:0] txCnt;
    logic [7:0] txSh;
    logic [7:0] txByte;
    logic [7:0] txCur;
    logic rdBit;
    logic txLoad;
    logic txEnd;
    logic sdoR;
    logic sdoOeR;
    logic selR;

    // pin synchronisers, first stage feeds only the second
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            csS <= 2'h3;
            sckS <= 3'h0;
            sdiS <= 2'h0;
            polS <= 2'h0;
            phaS <= 2'h0;
        end else begin
            csS <= {csS[0], link.csN};
            sckS <= {sckS[1:0], link.sclk};
            sdiS <= {sdiS[0], link.sdi};
            polS <= {polS[0], cpolStrap};
            phaS <= {phaS[0], cphaStrap};
        end
    end

    assign selected = ~csS[1];
    assign rise = sckS[1] & ~sckS[2];
    assign fall = ~sckS[1] & sckS[2];
    assign lead = polS[1] ? fall : rise;
    assign trail = polS[1] ? rise : fall;
    // edges only count while selected
    assign capE = selected & (phaS[1] ? trail : lead);
    assign shfE = selected & (phaS[1] ? lead : trail);
    assign lsb = orderR[spi_reg_pkg::ORDER_B0]
        | orderR[spi_reg_pkg::ORDER_B1];

    // control word collection
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !selected) begin
            bitCnt <= 5'h00;
            cwSh <= 15'h0000;
        end else if (capE && !cwDone) begin
            bitCnt <= bitCnt + 5'h01;
            cwSh <= {cwSh[13:0], sdiS[1]};
        end
    end

    assign cwDone = (bitCnt == spi_reg_pkg::CW_BITS);
    assign lastCw = capE && (bitCnt == spi_reg_pkg::CW_BITS - 5'h01);
    assign cwWord = {cwSh, sdiS[1]};

    // decode, then step the address through a burst
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !selected) begin
            rdR <= 1'b0;
            burstR <= 1'b0;
            addrR <= 14'h0000;
        end else if (lastCw) begin
            rdR <= cwWord[15];
            burstR <= cwWord[0];
            addrR <= lsb ? spi_reg_pkg::rev14(cwWord[14:1])
                : cwWord[14:1];
        end else if (burstR && (commit || txLoad)) begin
            addrR <= addrR + 14'h0001;
        end
    end

    // single transfers ignore anything after their byte
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !selected) begin
            doneR <= 1'b0;
        end else if (!burstR && (commit || txEnd)) begin
            doneR <= 1'b1;
        end
    end

    assign wrBit = capE && cwDone && !rdR && !doneR;
    assign rxByte = lsb ? {sdiS[1], rxSh[7:1]}
        : {rxSh[6:0], sdiS[1]};
    assign commit = wrBit && (rxCnt == spi_reg_pkg::BYTE_LAST);

    // write byte assembly; a cut-off byte never commits
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !selected) begin
            rxCnt <= 3'h0;
            rxSh <= 8'h00;
        end else if (wrBit) begin
            rxCnt <= rxCnt + 3'h1;
            rxSh <= rxByte;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            regWrEn <= 1'b0;
            regWrAddr <= 14'h0000;
            regWrData <= 8'h00;
        end else begin
            regWrEn <= commit && (addrR != spi_reg_pkg::ORDER_ADDR);
            if (commit) begin
                regWrAddr <= addrR;
                regWrData <= rxByte;
            end
        end
    end

    // bit-order register lives in the port itself
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            orderR <= spi_reg_pkg::ORDER_RST;
        end else if (commit && (addrR == spi_reg_pkg::ORDER_ADDR)) begin
            orderR <= rxByte;
        end
    end

    assign rdBit = shfE && cwDone && rdR && !doneR;
    assign txLoad = rdBit && (txCnt == 3'h0);
    assign txEnd = rdBit && (txCnt == spi_reg_pkg::BYTE_LAST);
    // prefetched byte: address was presented half a bit period earlier for the first byte, a byte period earlier for later burst bytes
    assign txByte = (addrR == spi_reg_pkg::ORDER_ADDR) ? orderR
        : regRdData;
    assign txCur = (txCnt == 3'h0) ? txByte : txSh;

    // read data shifter and output enable
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !selected) begin
            txCnt <= 3'h0;
            txSh <= 8'h00;
            sdoR <= 1'b0;
            sdoOeR <= 1'b0;
        end else if (rdBit) begin
            txCnt <= txCnt + 3'h1;
            sdoOeR <= 1'b1;
            sdoR <= lsb ? txCur[0] : txCur[7];
            txSh <= lsb ? {1'b0, txCur[7:1]} : {txCur[6:0], 1'b0};
        end else if (shfE && doneR) begin
            sdoOeR <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            selR <= 1'b0;
        end else begin
            selR <= selected;
        end
    end

    assign link.sdo = sdoR;
    assign link.sdoOe = sdoOeR;
    assign regRdAddr = addrR;
    assign orderReg = orderR;
    assign selActive = selR;
endmodule : spi_slave_end
`default_nettype wire

// ==== hw/spi_master_end.sv ====
// host end: AHB-Lite controlled serial bus master
`default_nettype none
module spi_master_end (
    input wire logic sys_clk,
    input wire logic rst_n,
    spi_link_if.host link,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp
);
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_SETUP = 3'b001,
        S_SHIFT = 3'b010,
        S_GAP = 3'b011,
        S_HOLD = 3'b100
    } state_e;

    state_e state;
    logic take;
    logic wrPend;
    logic [31:0] wrOfs;
    logic wrCfg;
    logic wrCmd;
    logic wrTx;
    logic rdRx;
    logic [2:0] cfgR;
    logic idleLvl;
    logic cpha;
    logic lsb;
    logic [7:0] txDataR;
    logic txFull;
    logic txTake;
    logic [7:0] rxDataR;
    logic rxValid;
    logic rxSet;
    logic [1:0] sdoS;
    logic [3:0] halfCnt;
    logic tick;
    logic phB;
    logic [4:0] bitsLeft;
    logic [15:0] sh;
    logic [7:0] rxSh;
    logic [8:0] bytesLeft;
    logic rwR;
    logic inData;
    logic [13:0] cmdAddr;

    assign take = hsel && htrans[1] && hready;
    assign wrCfg = wrPend && (wrOfs == spi_reg_pkg::OFS_CFG);
    assign wrCmd = wrPend && (wrOfs == spi_reg_pkg::OFS_CMD);
    assign wrTx = wrPend && (wrOfs == spi_reg_pkg::OFS_TX);
    assign rdRx = take && !hwrite && (haddr == spi_reg_pkg::OFS_RX);
    assign idleLvl = cfgR[spi_reg_pkg::CFG_CPOL];
    assign cpha = cfgR[spi_reg_pkg::CFG_CPHA];
    assign lsb = cfgR[spi_reg_pkg::CFG_LSB];
    assign tick = (halfCnt == 4'h0);
    assign cmdAddr = hwdata[13:0];

    // AHB-Lite slave: zero wait, always OKAY
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wrPend <= 1'b0;
            wrOfs <= 32'h0000_0000;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wrPend <= take && hwrite;
            wrOfs <= haddr;
            if (take && !hwrite) begin
                case (haddr)
                    spi_reg_pkg::OFS_CFG: hrdata <= {29'h0000_0000, cfgR};
                    spi_reg_pkg::OFS_TX: hrdata <= {24'h00_0000, txDataR};
                    spi_reg_pkg::OFS_RX: hrdata <= {24'h00_0000, rxDataR};
                    spi_reg_pkg::OFS_STAT: hrdata <= {29'h0000_0000, rxValid,
                        !txFull, state != S_IDLE};
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cfgR <= spi_reg_pkg::CFG_RST;
        end else if (wrCfg) begin
            cfgR <= hwdata[2:0];
        end
    end

    // holding flags: set wins over a same-cycle clear (hardware set for rxValid, software set for txFull)
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            txDataR <= 8'h00;
            txFull <= 1'b0;
            rxValid <= 1'b0;
        end else begin
            if (wrTx) begin
                txDataR <= hwdata[7:0];
            end
            txFull <= wrTx || (txFull && !txTake);
            rxValid <= rxSet || (rxValid && !rdRx);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sdoS <= 2'h0;
        end else begin
            sdoS <= {sdoS[0], link.sdo};
        end
    end

    assign txTake = (state == S_GAP) && (bytesLeft != 9'h000)
        && !rwR && txFull;
    assign rxSet = (state == S_SHIFT) && tick && phB
        && (bitsLeft == 5'h01) && inData && rwR;

    // transaction engine; host alone starts frames and makes the clock
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state <= S_IDLE;
            halfCnt <= 4'h0;
            phB <= 1'b0;
            bitsLeft <= 5'h00;
            sh <= 16'h0000;
            rxSh <= 8'h00;
            rxDataR <= 8'h00;
            bytesLeft <= 9'h000;
            rwR <= 1'b0;
            inData <= 1'b0;
            link.csN <= 1'b1;
            link.sclk <= 1'b0;
            link.sdi <= 1'b0;
            link.sdiOe <= 1'b0;
        end else if (wrCmd && hwdata[spi_reg_pkg::CMD_ABORT]) begin
            state <= S_IDLE;
            link.csN <= 1'b1;
        end else begin
            halfCnt <= tick ? spi_reg_pkg::HALF_CYC - 4'h1 : halfCnt - 4'h1;
            case (state)
                S_IDLE: begin
                    link.csN <= 1'b1;
                    link.sclk <= idleLvl;
                    link.sdiOe <= 1'b0;
                    if (wrCmd) begin
                        state <= S_SETUP;
                        link.csN <= 1'b0;
                        link.sdiOe <= 1'b1;
                        halfCnt <= spi_reg_pkg::HALF_CYC - 4'h1;
                        rwR <= hwdata[spi_reg_pkg::CMD_RW];
                        inData <= 1'b0;
                        bitsLeft <= spi_reg_pkg::CW_BITS;
                        bytesLeft <= {1'b0, hwdata[spi_reg_pkg::CMD_CNT +: 8]}
                            + 9'h001;
                        sh <= {hwdata[spi_reg_pkg::CMD_RW],
                            lsb ? spi_reg_pkg::rev14(cmdAddr) : cmdAddr,
                            hwdata[spi_reg_pkg::CMD_BURST]};
                    end
                end
                S_SETUP: begin
                    if (tick) begin
                        state <= S_SHIFT;
                        phB <= 1'b0;
                        link.sdi <= sh[15];
                        link.sclk <= idleLvl ^ cpha;
                    end
                end
                S_SHIFT: begin
                    if (tick && !phB) begin
                        phB <= 1'b1;
                        rxSh <= {rxSh[6:0], sdoS[1]};
                        link.sclk <= idleLvl ^ !cpha;
                    end else if (tick) begin
                        phB <= 1'b0;
                        sh <= {sh[14:0], 1'b0};
                        bitsLeft <= bitsLeft - 5'h01;
                        if (bitsLeft == 5'h01) begin
                            state <= S_GAP;
                            link.sclk <= idleLvl;
                            if (inData) begin
                                bytesLeft <= bytesLeft - 9'h001;
                            end
                            if (rxSet) begin
                                rxDataR <= lsb ? spi_reg_pkg::rev8(rxSh) : rxSh;
                            end
                        end else begin
                            link.sdi <= sh[14];
                            link.sclk <= idleLvl ^ cpha;
                        end
                    end
                end
                S_GAP: begin
                    halfCnt <= spi_reg_pkg::HALF_CYC - 4'h1;
                    if (bytesLeft == 9'h000) begin
                        state <= S_HOLD;
                    end else if (rwR ? !rxValid : txFull) begin
                        state <= S_SHIFT;
                        phB <= 1'b0;
                        inData <= 1'b1;
                        bitsLeft <= spi_reg_pkg::BYTE_BITS;
                        link.sclk <= idleLvl ^ cpha;
                        link.sdiOe <= !rwR;
                        sh <= {lsb ? spi_reg_pkg::rev8(txDataR) : txDataR,
                            8'h00};
                        link.sdi <= rwR ? 1'b0
                            : (lsb ? txDataR[0] : txDataR[7]);
                    end
                end
                S_HOLD: begin
                    if (tick) begin
                        state <= S_IDLE;
                        link.csN <= 1'b1;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule : spi_master_end
`default_nettype wire

// ==== sim/spi_link_sva.sv ====
// concurrent checks on the serial link joining the two ends
`default_nettype none
module spi_link_sva (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic csN,
    input wire logic sclk,
    input wire logic sdiOe,
    input wire logic sdo,
    input wire logic sdoOe
);
    logic sclkQ_r;
    logic [7:0] edgeCnt_r;
    logic [3:0] sinceEdge_r;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge sys_clk) begin
        sclkQ_r <= sclk;
    end
    // clock transitions seen within the current frame
    always_ff @(posedge sys_clk) begin
        if (!rst_n || csN) begin
            edgeCnt_r <= 8'h00;
        end else if (sclk != sclkQ_r && edgeCnt_r != 8'hff) begin
            edgeCnt_r <= edgeCnt_r + 8'h01;
        end
    end
    // cycles since the last clock transition
    always_ff @(posedge sys_clk) begin
        if (!rst_n || sclk != sclkQ_r) begin
            sinceEdge_r <= 4'h0;
        end else if (sinceEdge_r != 4'hf) begin
            sinceEdge_r <= sinceEdge_r + 4'h1;
        end
    end
    a_sdo_idle_off: assert property (csN [*5] |-> !sdoOe)
        else $error("sdo enabled while deselected");
    a_sdo_sel_only: assert property ($rose(sdoOe) |-> !csN)
        else $error("sdo enable rose outside a frame");
    a_sdo_drop_end: assert property ($rose(csN) |-> ##[1:6] !sdoOe)
        else $error("sdo still enabled after deselect");
    a_no_contend: assert property (sdoOe |-> !sdiOe)
        else $error("both ends drive the data line");
    a_sclk_setup: assert property ($fell(csN) |=> $stable(sclk) [*6])
        else $error("clock left idle level too soon after select");
    a_sclk_half: assert property
        (!csN && $changed(sclk) |=> (csN || $stable(sclk)) [*3])
        else $error("clock half period too short");
    a_sdo_on_edge: assert property
        (!csN && sdoOe && $past(sdoOe) && $changed(sdo)
            |-> sinceEdge_r <= 4'h6)
        else $error("sdo changed away from a shift edge");
    a_read_after_cw: assert property
        (sdoOe && !csN |-> edgeCnt_r >= 8'h20)
        else $error("sdo driven before control word ended");
endmodule : spi_link_sva
`default_nettype wire

// ==== sim/tb.sv ====
// self-checking bench joining host and device ends of the serial port
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cpolStrap = 1'b0;
    logic cphaStrap = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hreadyout, hresp, regWrEn, selActive, sclkQ;
    logic [31:0] hrdata, rd;
    logic [13:0] regWrAddr, regRdAddr;
    logic [7:0] regWrData, regRdData, orderReg, lastRd, rdSr;
    logic [7:0] mem [16384];
    logic [7:0] bufB [4];
    logic [7:0] gotB [4];
    logic [23:0] wireSr, lastFrame;
    int fail_count = 0;
    int n_checks = 0;
    int wrCount = 0;
    int bitCnt = 0;
    int lastCnt = 0;
    always #10 sys_clk = ~sys_clk;
    spi_link_if u_spi_link_if ();
    spi_master_end u_spi_master_end (.sys_clk(sys_clk), .rst_n(rst_n),
        .link(u_spi_link_if.host), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp));
    spi_slave_end u_spi_slave_end (.sys_clk(sys_clk), .rst_n(rst_n),
        .link(u_spi_link_if.device), .cpolStrap(cpolStrap),
        .cphaStrap(cphaStrap), .regWrEn(regWrEn), .regWrAddr(regWrAddr),
        .regWrData(regWrData), .regRdAddr(regRdAddr),
        .regRdData(regRdData), .orderReg(orderReg), .selActive(selActive));
    spi_link_sva u_spi_link_sva (.sys_clk(sys_clk), .rst_n(rst_n),
        .csN(u_spi_link_if.csN), .sclk(u_spi_link_if.sclk),
        .sdiOe(u_spi_link_if.sdiOe), .sdo(u_spi_link_if.sdo),
        .sdoOe(u_spi_link_if.sdoOe));
    // register space behind the device
    assign regRdData = mem[regRdAddr];
    always @(posedge sys_clk) begin
        if (regWrEn === 1'b1) begin
            mem[regWrAddr] <= regWrData;
            wrCount <= wrCount + 1;
        end
    end
    // wire shadow taken at the device capture edge
    always @(posedge sys_clk) begin
        sclkQ <= u_spi_link_if.sclk;
        if (u_spi_link_if.csN) begin
            if (bitCnt != 0) begin
                lastFrame <= wireSr;
                lastCnt <= bitCnt;
                lastRd <= rdSr;
            end
            bitCnt <= 0;
        end else if (u_spi_link_if.sclk !== sclkQ &&
                u_spi_link_if.sclk === ~(cpolStrap ^ cphaStrap)) begin
            wireSr <= {wireSr[22:0], u_spi_link_if.sdi};
            rdSr <= {rdSr[6:0], u_spi_link_if.sdo};
            bitCnt <= bitCnt + 1;
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done
    task automatic chk(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic tmo(input int k, input int lim);
        if (k >= lim) begin
            fail_count++;
            $display("BAD wait expected done seen timeout");
            test_done();
        end
    endtask : tmo
    task automatic ahb(input logic w, input logic [31:0] a,
            input logic [31:0] wd);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        htrans <= 2'b00;
        hwdata <= wd;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        rd = hrdata;
        tmo(n, 50);
    endtask : ahb
    task automatic wait_stat(input int b, input logic v);
        int k;
        k = 0;
        do begin
            ahb(1'b0, spi_reg_pkg::OFS_STAT, 32'h0000_0000);
            k++;
        end while (rd[b] !== v && k < 2000);
        tmo(k, 2000);
    endtask : wait_stat
    task automatic wait_bits(input int n);
        int k;
        k = 0;
        while (bitCnt < n && k < 5000) begin
            @(posedge sys_clk);
            k++;
        end
        tmo(k, 5000);
    endtask : wait_bits
    task automatic mode(input logic pol, input logic pha, input logic lsb);
        cpolStrap <= pol;
        cphaStrap <= pha;
        ahb(1'b1, spi_reg_pkg::OFS_CFG, {29'h0, lsb, pha, pol});
        ahb(1'b0, spi_reg_pkg::OFS_CFG, 32'h0000_0000);
        chk("cfg readback", {29'h0, lsb, pha, pol}, rd);
    endtask : mode
    task automatic xfer(input logic rw, input logic [13:0] a, input int n);
        if (!rw) begin
            ahb(1'b1, spi_reg_pkg::OFS_TX, {24'h00_0000, bufB[0]});
        end
        ahb(1'b1, spi_reg_pkg::OFS_CMD,
            {8'h00, 8'(n - 1), (n > 1), rw, a});
        for (int i = 0; i < n; i++) begin
            if (rw) begin
                wait_stat(spi_reg_pkg::ST_RXV, 1'b1);
                ahb(1'b0, spi_reg_pkg::OFS_RX, 32'h0000_0000);
                gotB[i] = rd[7:0];
            end else if (i > 0) begin
                wait_stat(spi_reg_pkg::ST_TXE, 1'b1);
                ahb(1'b1, spi_reg_pkg::OFS_TX, {24'h00_0000, bufB[i]});
            end
        end
        wait_stat(spi_reg_pkg::ST_BUSY, 1'b0);
    endtask : xfer
    task automatic chk_frame(input logic rw, input logic [13:0] a,
            input logic [7:0] d, input logic lsb);
        logic [13:0] aw;
        logic [7:0] dw;
        aw = a;
        dw = d;
        if (lsb) begin
            aw = {<<{a}};
            dw = {<<{d}};
        end
        chk("bit count", 32'h0000_0018, lastCnt);
        chk("control word", {rw, aw, 1'b0}, lastFrame[23:8]);
        chk("wire byte", dw, rw ? lastRd : lastFrame[7:0]);
    endtask : chk_frame
    task automatic t_reset();
        chk("order reg", spi_reg_pkg::ORDER_RST, orderReg);
        chk("sdo enable", 1'b0, u_spi_link_if.sdoOe);
        chk("select", 1'b1, u_spi_link_if.csN);
        chk("sel active", 1'b0, selActive);
        ahb(1'b0, spi_reg_pkg::OFS_CFG, 32'h0000_0000);
        chk("cfg reset", spi_reg_pkg::CFG_RST, rd);
        ahb(1'b0, spi_reg_pkg::OFS_STAT, 32'h0000_0000);
        chk("status reset", 32'h0000_0002, rd);
        ahb(1'b1, 32'h0000_0020, 32'hffff_ffff);
        ahb(1'b0, 32'h0000_0020, 32'h0000_0000);
        chk("unmapped", 32'h0000_0000, rd);
        chk("hresp", 1'b0, hresp);
        chk("hready", 1'b1, hreadyout);
    endtask : t_reset
    task automatic t_modes();
        logic [13:0] a;
        for (int m = 0; m < 4; m++) begin
            a = 14'h1555 ^ 14'(m);
            bufB[0] = 8'hc3 ^ 8'(m * 17);
            mode(m[0], m[1], 1'b0);
            xfer(1'b0, a, 1);
            chk("stored byte", bufB[0], mem[a]);
            chk_frame(1'b0, a, bufB[0], 1'b0);
            xfer(1'b1, a, 1);
            chk("read byte", bufB[0], gotB[0]);
            chk_frame(1'b1, a, bufB[0], 1'b0);
            chk("clock idle", m[0], u_spi_link_if.sclk);
        end
    endtask : t_modes
    task automatic t_burst();
        int c;
        bufB = '{8'ha1, 8'h21, 8'hb2, 8'hc3};
        mode(1'b0, 1'b0, 1'b0);
        c = wrCount;
        xfer(1'b0, 14'h3ffe, 4);
        chk("burst writes", 32'h0000_0003, wrCount - c);
        chk("byte 3ffe", 8'ha1, mem[14'h3ffe]);
        chk("order byte", 8'h21, orderReg);
        chk("byte 0000", 8'hb2, mem[14'h0000]);
        chk("byte 0001", 8'hc3, mem[14'h0001]);
        xfer(1'b1, 14'h3ffe, 4);
        for (int i = 0; i < 4; i++) begin
            chk("burst read", bufB[i], gotB[i]);
        end
    endtask : t_burst
    task automatic t_order();
        logic [7:0] v;
        for (int j = 0; j < 2; j++) begin
            v = (j == 0) ? 8'h10 : 8'h08;
            bufB[0] = v;
            xfer(1'b0, spi_reg_pkg::ORDER_ADDR, 1);
            chk_frame(1'b0, spi_reg_pkg::ORDER_ADDR, v, j[0]);
            chk("order reg", v, orderReg);
            mode(1'b0, 1'b0, 1'b1);
            xfer(1'b1, spi_reg_pkg::ORDER_ADDR, 1);
            chk("order readback", v, gotB[0]);
            bufB[0] = 8'h5a ^ v;
            xfer(1'b0, 14'h0123, 1);
            chk_frame(1'b0, 14'h0123, bufB[0], 1'b1);
            chk("stored lsb", bufB[0], mem[14'h0123]);
            xfer(1'b1, 14'h0123, 1);
            chk("read lsb", bufB[0], gotB[0]);
            chk_frame(1'b1, 14'h0123, bufB[0], 1'b1);
        end
        bufB[0] = 8'h00;
        xfer(1'b0, spi_reg_pkg::ORDER_ADDR, 1);
        chk("order cleared", 8'h00, orderReg);
        mode(1'b0, 1'b0, 1'b0);
    endtask : t_order
    task automatic t_abort();
        int c;
        bufB[0] = 8'h11;
        xfer(1'b0, 14'h0042, 1);
        c = wrCount;
        ahb(1'b1, spi_reg_pkg::OFS_CMD, 32'h0000_0042);
        wait_bits(16);
        chk("select low", 32'h0000_0000, u_spi_link_if.csN);
        chk("sel active", 32'h0000_0001, selActive);
        ahb(1'b1, spi_reg_pkg::OFS_TX, 32'h0000_00ee);
        ahb(1'b0, spi_reg_pkg::OFS_TX, 32'h0000_0000);
        chk("tx readback", 32'h0000_00ee, rd);
        wait_bits(23);
        ahb(1'b1, spi_reg_pkg::OFS_CMD, 32'h8000_0000);
        wait_stat(spi_reg_pkg::ST_BUSY, 1'b0);
        chk("aborted writes", 32'h0000_0000, wrCount - c);
        chk("kept byte", 8'h11, mem[14'h0042]);
        chk("abort bits", 32'h0000_0017, lastCnt);
        xfer(1'b1, 14'h0042, 1);
        chk("after abort", 8'h11, gotB[0]);
    endtask : t_abort
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t_reset();
        t_modes();
        t_burst();
        t_order();
        t_abort();
        test_done();
    end
endmodule : tb
`default_nettype wire
